// >>> verilog/chan_xfer_pkg.sv
/*
 * Constants, bit positions and state encoding for the buffered channel transfer block.
 * Assumes every file that needs these names refers to them as chan_xfer_pkg::name.
 */
`default_nettype none

package chan_xfer_pkg;

	// ----------------------------------------------------------------
	// widths and buffer depth
	// ----------------------------------------------------------------
	localparam int BYTE_W    = 8;
	localparam int CNT_W     = 16;
	localparam int CTL_W     = 8;
	localparam int BUF_DEPTH = 2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTL_XFER     = 0;
	localparam int CTL_WRITE    = 1;
	localparam int CTL_SUPP     = 5;
	localparam int INT_CNT_ZERO = 0;
	localparam int INT_CHAN     = 5;
	localparam int FLAG_CMD_OUT = 4;

	// ----------------------------------------------------------------
	// values after reset and fixed counts
	// ----------------------------------------------------------------
	localparam logic [CTL_W-1:0]  CTL_RST  = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

	// ----------------------------------------------------------------
	// handshake sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_REQ  = 2'b01,
		HS_DROP = 2'b10,
		HS_STOP = 2'b11
	} hs_state_t;

endpackage

`default_nettype wire

// >>> verilog/sync2.sv
/*
 * Two flip-flop synchroniser for a group of asynchronous channel lines.
 * Assumes the lines of a group are stable around the tag that qualifies them.
 */
`default_nettype none

module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         clk_en,
	// lines
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_r <= '0;
			q_r    <= '0;
		end else if (clk_en) begin
			meta_r <= d_async;
			q_r    <= meta_r;
		end
	end

	assign q = q_r;

endmodule

`default_nettype wire

// >>> verilog/byte_pair_buf.sv
/*
 * Two-stage byte buffer between the microprogram and the channel.
 * Assumes the caller never pushes when full nor pops when empty.
 */
`default_nettype none

module byte_pair_buf (
	// clock and reset
	input  wire logic                              clk,
	input  wire logic                              sys_rst,
	input  wire logic                              clk_en,
	input  wire logic                              flush,
	// fill side
	input  wire logic                              push,
	input  wire logic [chan_xfer_pkg::BYTE_W-1:0]  push_data,
	// drain side
	input  wire logic                              pop,
	output logic      [chan_xfer_pkg::BYTE_W-1:0]  head,
	output logic                                   full,
	output logic                                   empty
);

	logic [chan_xfer_pkg::BYTE_W-1:0] stage_r [0:chan_xfer_pkg::BUF_DEPTH-1];
	logic       wr_ptr_r;
	logic       rd_ptr_r;
	logic [1:0] fill_r;

	wire do_push = push && !full;
	wire do_pop  = pop && !empty;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage_r[0] <= chan_xfer_pkg::BYTE_RST;
			stage_r[1] <= chan_xfer_pkg::BYTE_RST;
			wr_ptr_r   <= 1'b0;
			rd_ptr_r   <= 1'b0;
			fill_r     <= 2'h0;
		end else if (clk_en) begin
			if (flush) begin
				wr_ptr_r <= 1'b0;
				rd_ptr_r <= 1'b0;
				fill_r   <= 2'h0;
			end else begin
				if (do_push) begin
					stage_r[wr_ptr_r] <= push_data;
					wr_ptr_r          <= ~wr_ptr_r;
				end
				if (do_pop)
					rd_ptr_r <= ~rd_ptr_r;
				fill_r <= fill_r + {1'b0, do_push} - {1'b0, do_pop};
			end
		end
	end

	assign head  = stage_r[rd_ptr_r];
	assign full  = (fill_r == 2'(chan_xfer_pkg::BUF_DEPTH));
	assign empty = (fill_r == 2'h0);

endmodule

`default_nettype wire

// >>> verilog/channel_buffered_transfer.sv
/*
 * Buffered byte transfer between a bus-and-tag channel and the microprogram.
 * Assumes channel lines are asynchronous; microprogram strobes are one-cycle
 * pulses on clk.
 */
`default_nettype none

// Operation
// - transfer bit 0 starts, clearing ends it
// - control bit 1 selects write, else read
// - decrement count on each completed handshake
// - at zero, latch sets and requests stop
// - latch sets on handshake with count one
// - count-zero latch is interrupt register bit 0
// - count reload clears the count-zero latch
// - count load only while transfer bit clear
// - transfer clear: data registers mirror bus lines
// - transfer set: two-byte buffer in path
// - read: raise buffer-ready and queue-empty conditions
// - loaded byte driven on bus, request raised
// - both stages full clears buffer-ready
// - matching data out or service out accepts, command out rejects
// - alternate data-in and service-in requests
// - truncation: no decrement, flag interrupt bit 5
// - address out halts; microprogram clears transfer
// - suppressible transfer waits while suppress out
// - outbound load refused while buffer not ready
module channel_buffered_transfer (
	// clock and reset
	input  wire logic                              clk,
	input  wire logic                              sys_rst,
	input  wire logic                              clk_en,
	// microprogram side
	input  wire logic                              ctl_wr,
	input  wire logic [chan_xfer_pkg::CTL_W-1:0]   ctl_data,
	input  wire logic                              count_load,
	input  wire logic [chan_xfer_pkg::CNT_W-1:0]   count_data,
	input  wire logic                              outbound_load,
	input  wire logic [chan_xfer_pkg::BYTE_W-1:0]  outbound_data,
	input  wire logic                              inbound_take,
	input  wire logic                              man_data_in,
	input  wire logic                              man_service_in,
	// microprogram status
	output logic      [chan_xfer_pkg::CTL_W-1:0]   channel_control_reg,
	output logic      [chan_xfer_pkg::CNT_W-1:0]   byte_count_reg,
	output logic      [chan_xfer_pkg::BYTE_W-1:0]  inbound_data_reg,
	output logic      [7:0]                        int_reg,
	output logic      [7:0]                        channel_flag_reg,
	output logic                                   buffer_ready_cond,
	output logic                                   queue_empty_cond,
	// channel lines
	input  wire logic [chan_xfer_pkg::BYTE_W-1:0]  bus_out,
	input  wire logic                              data_out,
	input  wire logic                              service_out,
	input  wire logic                              command_out,
	input  wire logic                              address_out,
	input  wire logic                              suppress_out,
	output logic      [chan_xfer_pkg::BYTE_W-1:0]  bus_in,
	output logic                                   data_in,
	output logic                                   service_in
);

	// ----------------------------------------------------------------
	// channel line synchronisation
	// ----------------------------------------------------------------
	logic [chan_xfer_pkg::BYTE_W-1:0] s_bus_out;
	logic s_data_out;
	logic s_svc_out;
	logic s_cmd_out;
	logic s_addr_out;
	logic s_supp_out;

	// bus and tags share one delay so data is settled when its tag arrives
	sync2 #(.W(chan_xfer_pkg::BYTE_W + 5)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.d_async ({bus_out, data_out, service_out, command_out, address_out, suppress_out}),
		.q       ({s_bus_out, s_data_out, s_svc_out, s_cmd_out, s_addr_out, s_supp_out})
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [chan_xfer_pkg::CTL_W-1:0]  ctl_r;
	logic [chan_xfer_pkg::CTL_W-1:0]  ctl_nxt;
	logic [chan_xfer_pkg::CNT_W-1:0]  cnt_r;
	logic [chan_xfer_pkg::CNT_W-1:0]  cnt_nxt;
	logic                             czero_r;
	logic                             czero_nxt;
	logic                             trunc_r;
	logic                             trunc_nxt;
	logic                             halt_r;
	logic                             halt_nxt;
	logic                             use_svc_r;
	logic                             use_svc_nxt;
	chan_xfer_pkg::hs_state_t         state_r;
	chan_xfer_pkg::hs_state_t         state_nxt;
	logic [chan_xfer_pkg::BYTE_W-1:0] bus_in_r;
	logic [chan_xfer_pkg::BYTE_W-1:0] bus_in_nxt;
	logic [chan_xfer_pkg::BYTE_W-1:0] ibd_r;
	logic [chan_xfer_pkg::BYTE_W-1:0] ibd_nxt;
	logic                             di_r;
	logic                             si_r;
	logic                             cbr_r;
	logic                             qe_r;
	logic [7:0]                       int_r;
	logic [7:0]                       int_nxt;
	logic [7:0]                       flag_r;
	logic [7:0]                       flag_nxt;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [chan_xfer_pkg::BYTE_W-1:0] buf_head;
	logic buf_full;
	logic buf_empty;

	wire xfer = ctl_r[chan_xfer_pkg::CTL_XFER];
	wire wr   = ctl_r[chan_xfer_pkg::CTL_WRITE];
	wire supp = ctl_r[chan_xfer_pkg::CTL_SUPP];

	wire out_tag  = use_svc_r ? s_svc_out : s_data_out;
	wire accept   = (state_r == chan_xfer_pkg::HS_REQ) && xfer && out_tag;
	wire trunc_ev = (state_r == chan_xfer_pkg::HS_REQ) && xfer && s_cmd_out && !out_tag;
	wire supp_hold = supp && s_supp_out;
	wire room     = wr ? !buf_full : !buf_empty;
	wire may_req  = xfer && !czero_r && !trunc_r && !halt_r && !supp_hold && room;
	wire tags_low = !s_data_out && !s_svc_out && !s_cmd_out;

	// the count is asynchronous to the microprogram while a transfer runs
	wire cnt_load_ok = count_load && !xfer;
	// a load into a full read buffer would overwrite an unsent byte
	wire obd_load_ok = outbound_load && xfer && !wr && !buf_full;
	wire ibd_take_ok = inbound_take && xfer && wr && !buf_empty;
	wire xfer_start  = ctl_wr && ctl_data[chan_xfer_pkg::CTL_XFER];

	// read: microprogram fills, channel drains; write: the reverse
	wire buf_push = wr ? accept : obd_load_ok;
	wire buf_pop  = wr ? ibd_take_ok : accept;
	wire [chan_xfer_pkg::BYTE_W-1:0] buf_wdata = wr ? s_bus_out : outbound_data;

	byte_pair_buf u_buf (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.flush     (!xfer),
		.push      (buf_push),
		.push_data (buf_wdata),
		.pop       (buf_pop),
		.head      (buf_head),
		.full      (buf_full),
		.empty     (buf_empty)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			chan_xfer_pkg::HS_IDLE: begin
				if (may_req)
					state_nxt = chan_xfer_pkg::HS_REQ;
			end
			chan_xfer_pkg::HS_REQ: begin
				if (!xfer)
					state_nxt = chan_xfer_pkg::HS_IDLE;
				else if (accept)
					state_nxt = chan_xfer_pkg::HS_DROP;
				else if (trunc_ev)
					state_nxt = chan_xfer_pkg::HS_STOP;
			end
			chan_xfer_pkg::HS_DROP: begin
				if (tags_low || !xfer)
					state_nxt = chan_xfer_pkg::HS_IDLE;
			end
			chan_xfer_pkg::HS_STOP: begin
				if (!xfer)
					state_nxt = chan_xfer_pkg::HS_IDLE;
			end
			default: begin
				state_nxt = chan_xfer_pkg::HS_IDLE;
			end
		endcase
	end

	always_comb begin
		ctl_nxt = ctl_wr ? ctl_data : ctl_r;
		cnt_nxt = cnt_r;
		if (cnt_load_ok)
			cnt_nxt = count_data;
		else if (accept)
			cnt_nxt = cnt_r - chan_xfer_pkg::CNT_ONE;
		// set wins over reload; the two cannot meet since reload needs transfer clear
		czero_nxt = (accept && cnt_r == chan_xfer_pkg::CNT_ONE)
			|| (czero_r && !cnt_load_ok);
		trunc_nxt = trunc_ev || (trunc_r && !xfer_start);
		halt_nxt  = (xfer && s_addr_out) || (halt_r && !xfer_start);
		// first request of a transfer is data in, then alternate
		use_svc_nxt = !xfer ? 1'b0 : (accept ? !use_svc_r : use_svc_r);
	end

	always_comb begin
		if (xfer && !wr)
			bus_in_nxt = buf_head;
		else if (outbound_load && !xfer)
			bus_in_nxt = outbound_data;
		else
			bus_in_nxt = bus_in_r;
		ibd_nxt  = (xfer && wr) ? buf_head : s_bus_out;
		int_nxt  = 8'h00;
		int_nxt[chan_xfer_pkg::INT_CNT_ZERO] = czero_nxt;
		int_nxt[chan_xfer_pkg::INT_CHAN]     = trunc_nxt || halt_nxt;
		flag_nxt = 8'h00;
		flag_nxt[chan_xfer_pkg::FLAG_CMD_OUT] = trunc_nxt;
	end

	wire req_nxt = (state_nxt == chan_xfer_pkg::HS_REQ);
	wire di_nxt  = xfer ? (req_nxt && !use_svc_nxt) : man_data_in;
	wire si_nxt  = xfer ? (req_nxt && use_svc_nxt) : man_service_in;
	// read: a free stage; write: a byte waiting; queue empty also at count zero
	wire cbr_nxt = xfer && (wr ? !buf_empty : !buf_full);
	wire qe_nxt  = xfer && ((!wr && buf_empty) || czero_r);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_r     <= chan_xfer_pkg::CTL_RST;
			cnt_r     <= chan_xfer_pkg::CNT_RST;
			czero_r   <= 1'b0;
			trunc_r   <= 1'b0;
			halt_r    <= 1'b0;
			use_svc_r <= 1'b0;
			state_r   <= chan_xfer_pkg::HS_IDLE;
		end else if (clk_en) begin
			ctl_r     <= ctl_nxt;
			cnt_r     <= cnt_nxt;
			czero_r   <= czero_nxt;
			trunc_r   <= trunc_nxt;
			halt_r    <= halt_nxt;
			use_svc_r <= use_svc_nxt;
			state_r   <= state_nxt;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_in_r <= chan_xfer_pkg::BYTE_RST;
			ibd_r    <= chan_xfer_pkg::BYTE_RST;
			di_r     <= 1'b0;
			si_r     <= 1'b0;
			cbr_r    <= 1'b0;
			qe_r     <= 1'b0;
			int_r    <= 8'h00;
			flag_r   <= 8'h00;
		end else if (clk_en) begin
			bus_in_r <= bus_in_nxt;
			ibd_r    <= ibd_nxt;
			di_r     <= di_nxt;
			si_r     <= si_nxt;
			cbr_r    <= cbr_nxt;
			qe_r     <= qe_nxt;
			int_r    <= int_nxt;
			flag_r   <= flag_nxt;
		end
	end

	assign channel_control_reg = ctl_r;
	assign byte_count_reg      = cnt_r;
	assign inbound_data_reg    = ibd_r;
	assign int_reg             = int_r;
	assign channel_flag_reg    = flag_r;
	assign buffer_ready_cond   = cbr_r;
	assign queue_empty_cond    = qe_r;
	assign bus_in              = bus_in_r;
	assign data_in             = di_r;
	assign service_in          = si_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_START_XFER: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		ctl_wr && ctl_data[chan_xfer_pkg::CTL_XFER] |=> xfer && !$past(trunc_ev) |-> !trunc_r)
		else $error("transfer start did not clear truncation");
	AST_DEC: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		accept |=> cnt_r == $past(cnt_r) - chan_xfer_pkg::CNT_ONE)
		else $error("count not decremented on handshake");
	AST_CZ_SET: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		accept && cnt_r == chan_xfer_pkg::CNT_ONE |=> czero_r ##1 int_r[0])
		else $error("count-zero latch not set");
	AST_NO_REQ_ZERO: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		czero_r && state_r != chan_xfer_pkg::HS_REQ |=> state_r != chan_xfer_pkg::HS_REQ)
		else $error("request raised at count zero");
	AST_RELOAD: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		count_load && !xfer |=> !czero_r && cnt_r == $past(count_data))
		else $error("reload did not clear count-zero");
	AST_LOAD_LOCK: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		xfer && count_load && !accept |=> cnt_r == $past(cnt_r))
		else $error("count loaded during transfer");
	AST_TRUNC: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		trunc_ev |=> trunc_r && cnt_r == $past(cnt_r) && state_r == chan_xfer_pkg::HS_STOP)
		else $error("truncation mishandled");
	AST_SUPP: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		supp_hold && state_r == chan_xfer_pkg::HS_IDLE |=> !di_r && !si_r)
		else $error("request raised under suppress out");
	AST_FULL_CBR: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		xfer && !wr && buf_full |=> !cbr_r)
		else $error("buffer-ready set with both stages full");
	AST_DIRECT: assert property (@(posedge clk) disable iff (sys_rst || !clk_en)
		!xfer |=> ibd_r == $past(s_bus_out))
		else $error("inbound register not mirroring bus");

endmodule

`default_nettype wire

// >>> tb/chan_model.sv
/*
 * Behavioural model of the host channel facing the buffered transfer block.
 * Assumes clk is the block's clock; answers are launched on its rising edge.
 */
`default_nettype none

module chan_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// bench control
	input  wire logic       clr,
	input  wire logic       trunc,
	input  wire logic [3:0] dly,
	input  wire logic [7:0] bus_val,
	// channel lines
	input  wire logic [7:0] bus_in,
	input  wire logic       data_in,
	input  wire logic       service_in,
	output logic      [7:0] bus_out,
	output logic            data_out,
	output logic            service_out,
	output logic            command_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] log_b [0:15];
	logic       log_k [0:15];
	int         n;
	logic [3:0] wait_r;

	assign bus_out = bus_val;

	// the answer is held until the tag drops, as a real channel does
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{data_out, service_out, command_out} <= 3'h0;
			wait_r <= 4'h0;
			n <= 0;
		end else begin
			if (clr)
				n <= 0;
			if (!(data_in | service_in)) begin
				{data_out, service_out, command_out} <= 3'h0;
				wait_r <= 4'h0;
			end else if (!(data_out | service_out | command_out)) begin
				if (wait_r < dly)
					wait_r <= wait_r + 4'h1;
				else if (trunc)
					command_out <= 1'b1;
				else begin
					data_out <= data_in;
					service_out <= !data_in;
					log_b[n[3:0]] <= bus_in;
					log_k[n[3:0]] <= !data_in;
					n <= n + 1;
				end
			end
		end
	end
endmodule

`default_nettype wire

// >>> tb/channel_buffered_transfer_bench.sv
/*
 * Self-checking bench for the buffered channel transfer block, both directions.
 * Assumes the channel model in chan_model.sv answers every request it sees.
 */
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITC(c) for (k = 0; k < 400 && !(c); k++) @(posedge clk);

module channel_buffered_transfer_bench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {int n; logic [3:0] d;} row_t;

	logic clk, sys_rst, ctl_wr, count_load, outbound_load, man_data_in;
	logic clr, trunc, address_out, suppress_out, inbound_take;
	logic [7:0] ctl_data, outbound_data, bus_val, bus_out, bus_in;
	logic [15:0] count_data, byte_count_reg;
	logic [7:0] channel_control_reg, inbound_data_reg, int_reg, channel_flag_reg;
	logic buffer_ready_cond, queue_empty_cond, data_in, service_in;
	logic data_out, service_out, command_out;
	logic [3:0] dly;
	int miscompares, tests_run, k, i, r;
	row_t rows [3] = '{'{1, 4'h0}, '{3, 4'h4}, '{5, 4'h1}};

	channel_buffered_transfer u_dut (
		.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .ctl_wr(ctl_wr), .ctl_data(ctl_data),
		.count_load(count_load), .count_data(count_data), .outbound_load(outbound_load),
		.outbound_data(outbound_data), .inbound_take(inbound_take),
		.man_data_in(man_data_in),
		.man_service_in(1'b0), .channel_control_reg(channel_control_reg),
		.byte_count_reg(byte_count_reg), .inbound_data_reg(inbound_data_reg),
		.int_reg(int_reg), .channel_flag_reg(channel_flag_reg),
		.buffer_ready_cond(buffer_ready_cond), .queue_empty_cond(queue_empty_cond),
		.bus_out(bus_out), .data_out(data_out), .service_out(service_out),
		.command_out(command_out), .address_out(address_out), .suppress_out(suppress_out),
		.bus_in(bus_in), .data_in(data_in), .service_in(service_in));

	chan_model u_chan (
		.clk(clk), .sys_rst(sys_rst), .clr(clr), .trunc(trunc), .dly(dly),
		.bus_val(bus_val), .bus_in(bus_in), .data_in(data_in), .service_in(service_in),
		.bus_out(bus_out), .data_out(data_out), .service_out(service_out),
		.command_out(command_out));

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// count first, then control, as the microprogram must order them
	task automatic start(input logic [15:0] n, input logic [7:0] c);
		@(posedge clk);
		clr <= 1'b1;
		count_load <= 1'b1;
		count_data <= n;
		@(posedge clk);
		clr <= 1'b0;
		count_load <= 1'b0;
		ctl_wr <= 1'b1;
		ctl_data <= c;
		@(posedge clk);
		ctl_wr <= 1'b0;
	endtask

	task automatic push(input logic [7:0] b);
		@(posedge clk);
		outbound_load <= 1'b1;
		outbound_data <= b;
		@(posedge clk);
		outbound_load <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic stop(input string s);
		start(16'h0000, 8'h00);
		$display("test %s done", s);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		conclude();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{sys_rst, ctl_wr, count_load, outbound_load, man_data_in} = 5'b10000;
		{clr, trunc, address_out, suppress_out, inbound_take} = 5'h0;
		{ctl_data, outbound_data, bus_val, count_data, dly} = 44'h0;
		miscompares = 0;
		tests_run = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		`CHK({channel_control_reg, byte_count_reg, int_reg, data_in, service_in}, 34'h0)
		`CHK({buffer_ready_cond, queue_empty_cond}, 2'b00)
		$display("test reset done");
		for (r = 0; r < 3; r++) begin
			dly <= rows[r].d;
			start(rows[r].n[15:0], 8'h01);
			`CHK(int_reg[0], 1'b0)
			repeat (2) @(posedge clk);
			`CHK({buffer_ready_cond, queue_empty_cond}, 2'b11)
			for (i = 0; i < rows[r].n; i++) begin
				`WAITC(buffer_ready_cond === 1'b1)
				push(8'ha0 + i[7:0] + r[7:0] * 8'h10);
			end
			`WAITC(int_reg[0] === 1'b1)
			repeat (6) @(posedge clk);
			`CHK(int_reg[0], 1'b1)
			`CHK(byte_count_reg, 16'h0000)
			`CHK(u_chan.n, rows[r].n)
			`CHK({data_in, service_in, queue_empty_cond}, 3'b001)
			for (i = 0; i < rows[r].n; i++) begin
				`CHK(u_chan.log_b[i], 8'ha0 + i[7:0] + r[7:0] * 8'h10)
				`CHK(u_chan.log_k[i], i[0])
			end
			stop("row");
		end
		bus_val <= 8'h5a;
		man_data_in <= 1'b1;
		push(8'h3c);
		`CHK({inbound_data_reg, bus_in, data_in}, {8'h5a, 8'h3c, 1'b1})
		man_data_in <= 1'b0;
		stop("mirror");
		dly <= 4'hf;
		start(16'h0002, 8'h01);
		push(8'hc1);
		push(8'hc2);
		`CHK(buffer_ready_cond, 1'b0)
		push(8'hc3);
		start(16'h0009, 8'h01);
		`CHK(byte_count_reg, 16'h0002)
		`WAITC(int_reg[0] === 1'b1)
		`CHK({u_chan.log_b[0], u_chan.log_b[1]}, 16'hc1c2)
		stop("full");
		dly <= 4'h2;
		trunc <= 1'b1;
		start(16'h0003, 8'h01);
		push(8'hd1);
		`WAITC(channel_flag_reg[4] === 1'b1)
		repeat (6) @(posedge clk);
		`CHK({byte_count_reg, int_reg[5], queue_empty_cond}, {16'h0003, 2'b10})
		`CHK({data_in, service_in}, 2'b00)
		trunc <= 1'b0;
		stop("truncate");
		dly <= 4'hf;
		start(16'h0003, 8'h01);
		push(8'he1);
		address_out <= 1'b1;
		push(8'he2);
		repeat (40) @(posedge clk);
		`CHK({int_reg[5], data_in, service_in}, 3'b100)
		`CHK(u_chan.n, 1)
		address_out <= 1'b0;
		stop("halt");
		dly <= 4'h0;
		suppress_out <= 1'b1;
		start(16'h0001, 8'h21);
		push(8'hf1);
		repeat (10) @(posedge clk);
		`CHK(data_in, 1'b0)
		suppress_out <= 1'b0;
		`WAITC(data_in === 1'b1)
		`CHK(data_in, 1'b1)
		`WAITC(int_reg[0] === 1'b1)
		`CHK(u_chan.log_b[0], 8'hf1)
		stop("suppress");
		bus_val <= 8'h77;
		start(16'h0002, 8'h03);
		`WAITC(int_reg[0] === 1'b1)
		repeat (4) @(posedge clk);
		`CHK({inbound_data_reg, buffer_ready_cond}, {8'h77, 1'b1})
		`CHK(byte_count_reg, 16'h0000)
		`CHK(u_chan.n, 2)
		`CHK({u_chan.log_k[0], u_chan.log_k[1]}, 2'b01)
		inbound_take <= 1'b1;
		repeat (2) @(posedge clk);
		inbound_take <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(buffer_ready_cond, 1'b0)
		$display("test write done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		`CHK({channel_control_reg, int_reg, buffer_ready_cond, data_in}, 18'h0)
		$display("test reset done");
		conclude();
	end
endmodule

`default_nettype wire
